//--- inc/tap_timing_pkg.sv
// Shared constants, types and step functions for the tap timing block.
package tap_timing_pkg;

    // ========================================================================
    // Register map
    localparam logic [7:0] ADDR_TAP_SOURCE = 8'h22;
    localparam logic [7:0] ADDR_DURATION = 8'h26;
    localparam logic [7:0] ADDR_QUIET = 8'h27;
    localparam logic [7:0] ADDR_GAP = 8'h28;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] SOURCE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int SRC_ACTIVE_BIT = 7;
    localparam int SRC_AXIS_LSB = 4;
    localparam int SRC_DOUBLE_BIT = 3;
    localparam int SRC_POL_LSB = 0;

    // ========================================================================
    // Oversampling modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_LOW_NOISE = 2'h1;
    localparam logic [1:0] MODE_HIGH_RES = 2'h2;
    localparam logic [1:0] MODE_LOWPOWER = 2'h3;

    // ========================================================================
    // Timing: every step is a power of two times one base unit.
    localparam real STEP_UNIT_MS = 0.625;
    localparam real CLK_PERIOD_NS = 8.0;
    localparam int UNIT_CYCLES = int'(STEP_UNIT_MS * 1.0E6 / CLK_PERIOD_NS);
    localparam int UNIT_W = 17;
    localparam int STEP_W = 9;
    localparam int EXP_W = 4;
    localparam logic [7:0] LIMIT_MAX = 8'hFF;

    // Step caps as exponents of the base unit, filter on and off.
    localparam logic [3:0] CAP_ON_NORMAL = 4'h5;
    localparam logic [3:0] CAP_ON_LOW_NOISE = 4'h7;
    localparam logic [3:0] CAP_ON_HIGH_RES = 4'h2;
    localparam logic [3:0] CAP_ON_LOWPOWER = 4'h8;
    localparam logic [3:0] CAP_OFF_NORMAL = 4'h3;
    localparam logic [3:0] CAP_OFF_LOW_NOISE = 4'h5;
    localparam logic [3:0] CAP_OFF_HIGH_RES = 4'h0;
    localparam logic [3:0] CAP_OFF_LOWPOWER = 4'h6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FIRST = 3'h1,
        ST_QUIET = 3'h3,
        ST_GAP = 3'h2,
        ST_SECOND = 3'h6
    } tap_state_e;

    // ========================================================================
    // Functions
    // Rate period as a power of two of 1.25 ms.
    function automatic logic [3:0] rate_exp(input logic [2:0] rate);
        case (rate)
            3'h0: return 4'h0;
            3'h1: return 4'h1;
            3'h2: return 4'h2;
            3'h3: return 4'h3;
            3'h4: return 4'h4;
            3'h5: return 4'h6;
            3'h6: return 4'h7;
            default: return 4'h9;
        endcase
    endfunction

    // Duration step exponent; quiet and gap steps are one higher.
    function automatic logic [3:0] duration_step_exp(input logic [2:0] rate,
        input logic [1:0] mode, input logic filt);
        logic [3:0] e;
        logic [3:0] raw;
        logic [3:0] cap;
        e = rate_exp(rate);
        if (filt) begin
            raw = e + 4'h1;
            case (mode)
                MODE_NORMAL: cap = CAP_ON_NORMAL;
                MODE_LOW_NOISE: cap = CAP_ON_LOW_NOISE;
                MODE_HIGH_RES: cap = CAP_ON_HIGH_RES;
                default: cap = CAP_ON_LOWPOWER;
            endcase
        end else begin
            if (mode == MODE_LOWPOWER) begin
                raw = e;
            end else begin
                raw = (e == 4'h0) ? 4'h0 : e - 4'h1;
            end
            case (mode)
                MODE_NORMAL: cap = CAP_OFF_NORMAL;
                MODE_LOW_NOISE: cap = CAP_OFF_LOW_NOISE;
                MODE_HIGH_RES: cap = CAP_OFF_HIGH_RES;
                default: cap = CAP_OFF_LOWPOWER;
            endcase
        end
        return (raw > cap) ? cap : raw;
    endfunction

    function automatic logic [STEP_W-1:0] step_mask(input logic [3:0] ex);
        logic [STEP_W:0] one;
        one = {{STEP_W{1'b0}}, 1'b1} << ex;
        return STEP_W'(one - {{STEP_W{1'b0}}, 1'b1});
    endfunction

    function automatic logic [7:0] mag8(input logic [7:0] a);
        return a[7] ? 8'(~a + 8'h01) : a;
    endfunction

endpackage

//--- inc/step_tick_if.sv
// Link between the interval logic and one step tick generator.
`timescale 1ns/10ps
interface step_tick_if;
    logic clear;
    logic [3:0] exp;
    logic tick;
    modport ctl (output clear, output exp, input tick);
    modport gen (input clear, input exp, output tick);
endinterface

//--- design/tap_step_ticker.sv
// Step tick generator: one tick per 2**exp base units, restartable.
`timescale 1ns/10ps
module tap_step_ticker
    import tap_timing_pkg::*;
#(
    parameter int UNIT_COUNT = UNIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    step_tick_if.gen tk
);

    typedef struct packed {
        logic [UNIT_W-1:0] unit_cnt;
        logic [STEP_W-1:0] step_cnt;
        logic tick;
    } ticker_s;

    ticker_s s_q;
    ticker_s s_d;

    // ========================================================================
    // Next state
    // Clearing restarts the phase so an interval counts whole steps only.
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (tk.clear) begin
            s_d.unit_cnt = '0;
            s_d.step_cnt = '0;
        end else if (s_q.unit_cnt == UNIT_W'(UNIT_COUNT - 1)) begin
            s_d.unit_cnt = '0;
            if (s_q.step_cnt == step_mask(tk.exp)) begin
                s_d.step_cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.step_cnt = s_q.step_cnt + 1'b1;
            end
        end else begin
            s_d.unit_cnt = s_q.unit_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tk.tick = s_q.tick;

endmodule

//--- design/tap_pulse_timing.sv
// Tap pulse timing: duration limit, quiet interval and second-tap window.
//
// Function
// [R1] An 8-bit duration limit, reset zero, bounds a pulse over threshold.
// [R2] The longest duration limit is 255 duration steps.
// [R3] The step is chosen from sample rate, oversampling mode and filter.
// [R4] Filter on: duration step 1.25 ms at 800 Hz, caps 20/80/2.5/160 ms.
// [R5] Filter off: duration step 0.625 ms at 800 Hz, caps 5/20/0.625/40 ms.
// [R6] An 8-bit quiet interval, reset zero, follows a pulse and ignores pulses.
// [R7] Software must program the quiet interval for single and double tap.
// [R8] The quiet step follows rate, mode and filter and spans 255 steps.
// [R9] Filter on: quiet step 2.5 ms at 800 Hz, caps 40/160/5/320 ms.
// [R10] Filter off: quiet step 1.25 ms at 800 Hz, caps 10/40/1.25/80 ms.
// [R11] With double tap on, a second pulse must start within the gap window.
// [R12] The second pulse must beat the duration limit but may outlast the gap.
// [R13] The gap window uses the quiet step scheme and spans 255 steps.
// [R14] Each axis is compared to a 7-bit threshold and crossing starts timing.
// [R15] Reading the tap source register clears all flags and the event.
// [R16] With the latch enabled, status bits freeze once the event flag is set.
// [R17] Each interval counts whole steps and expires when it meets its limit.
`timescale 1ns/10ps
module tap_pulse_timing
    import tap_timing_pkg::*;
#(
    parameter int UNIT_COUNT = UNIT_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic sample_valid_in,
    input wire logic [7:0] accel_x_in,
    input wire logic [7:0] accel_y_in,
    input wire logic [7:0] accel_z_in,
    input wire logic [6:0] x_tap_threshold_in,
    input wire logic [6:0] y_tap_threshold_in,
    input wire logic [6:0] z_tap_threshold_in,
    input wire logic [2:0] output_sample_rate_in,
    input wire logic [1:0] oversample_mode_in,
    input wire logic tap_filter_enable_in,
    input wire logic event_latch_enable_in,
    input wire logic single_tap_enable_in,
    input wire logic double_tap_enable_in,
    output logic tap_event_pending_out
);

    typedef struct packed {
        tap_state_e st;
        logic [7:0] tl_cnt;
        logic [7:0] qw_cnt;
        logic [7:0] dur_lim;
        logic [7:0] quiet_lim;
        logic [7:0] gap_lim;
        logic [7:0] src;
        logic [7:0] rdata;
        logic [2:0] above;
        logic [2:0] neg;
        logic [2:0] ax_cap;
        logic [2:0] pol_cap;
        logic over_prev;
        logic dbl_done;
    } core_s;

    core_s s_q;
    core_s s_d;
    logic tl_clr;
    logic qw_clr;
    logic rep_single;
    logic rep_double;
    logic over;
    logic rise;
    logic src_rd;
    logic [3:0] dur_exp;

    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    step_tick_if tl_if ();
    step_tick_if qw_if ();

    tap_step_ticker #(.UNIT_COUNT(UNIT_COUNT)) u_tl_ticker (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .tk(tl_if.gen)
    );

    tap_step_ticker #(.UNIT_COUNT(UNIT_COUNT)) u_qw_ticker (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .tk(qw_if.gen)
    );

    // ========================================================================
    // Step selection
    assign dur_exp = duration_step_exp(output_sample_rate_in,
        oversample_mode_in, tap_filter_enable_in); // [R3] [R4] [R5]
    assign tl_if.exp = dur_exp;
    assign qw_if.exp = dur_exp + 4'h1; // [R8] [R9] [R10] [R13]
    assign tl_if.clear = tl_clr;
    assign qw_if.clear = qw_clr;

    assign over = |s_q.above;
    assign rise = over && !s_q.over_prev; // [R14]
    assign src_rd = reg_rd_in && (reg_addr_in == ADDR_TAP_SOURCE);

    // ========================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        tl_clr = 1'b0;
        qw_clr = 1'b0;
        rep_single = 1'b0;
        rep_double = 1'b0;
        s_d.over_prev = over;
        if (sample_valid_in) begin
            s_d.above[0] = mag8(accel_x_in) > 8'(x_tap_threshold_in); // [R14]
            s_d.above[1] = mag8(accel_y_in) > {1'b0, y_tap_threshold_in};
            s_d.above[2] = mag8(accel_z_in) > {1'b0, z_tap_threshold_in};
            s_d.neg = {accel_z_in[7], accel_y_in[7], accel_x_in[7]};
        end
        case (s_q.st)
            ST_IDLE: begin
                if (rise) begin
                    s_d.st = ST_FIRST;
                    tl_clr = 1'b1;
                    s_d.tl_cnt = 8'h00;
                    s_d.dbl_done = 1'b0;
                    s_d.ax_cap = s_q.above;
                    s_d.pol_cap = s_q.neg & s_q.above;
                end
            end
            ST_FIRST, ST_SECOND: begin
                // A pulse still over threshold at the limit is discarded.
                if (s_q.tl_cnt == s_q.dur_lim) begin
                    s_d.st = ST_IDLE; // [R1] [R12] [R17]
                end else if (!over) begin
                    rep_single = (s_q.st == ST_FIRST) && single_tap_enable_in;
                    rep_double = (s_q.st == ST_SECOND); // [R12]
                    s_d.dbl_done = (s_q.st == ST_SECOND);
                    s_d.st = ST_QUIET; // [R6]
                    qw_clr = 1'b1;
                    s_d.qw_cnt = 8'h00;
                end else if (tl_if.tick) begin
                    s_d.tl_cnt = s_q.tl_cnt + 8'h01; // [R2] [R17]
                end
            end
            ST_QUIET: begin
                // Pulses seen here are ignored.
                if (s_q.qw_cnt == s_q.quiet_lim) begin // [R6]
                    if (double_tap_enable_in && !s_q.dbl_done) begin
                        s_d.st = ST_GAP;
                        qw_clr = 1'b1;
                        s_d.qw_cnt = 8'h00;
                    end else begin
                        s_d.st = ST_IDLE;
                    end
                end else if (qw_if.tick) begin
                    s_d.qw_cnt = s_q.qw_cnt + 8'h01; // [R8] [R17]
                end
            end
            ST_GAP: begin
                if (s_q.qw_cnt == s_q.gap_lim) begin
                    s_d.st = ST_IDLE; // [R11]
                end else if (rise) begin
                    s_d.st = ST_SECOND; // [R11]
                    tl_clr = 1'b1;
                    s_d.tl_cnt = 8'h00;
                    s_d.ax_cap = s_q.above;
                    s_d.pol_cap = s_q.neg & s_q.above;
                end else if (qw_if.tick) begin
                    s_d.qw_cnt = s_q.qw_cnt + 8'h01; // [R13] [R17]
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // A read clears the source, but an event in the same cycle wins.
        if (src_rd) begin
            s_d.src = SOURCE_RESET; // [R15]
        end
        if (rep_single || rep_double) begin
            s_d.src[SRC_ACTIVE_BIT] = 1'b1;
            if (!(s_q.src[SRC_ACTIVE_BIT] && event_latch_enable_in
                && !src_rd)) begin
                s_d.src[SRC_AXIS_LSB +: 3] = s_q.ax_cap; // [R16]
                s_d.src[SRC_DOUBLE_BIT] = rep_double;
                s_d.src[SRC_POL_LSB +: 3] = s_q.pol_cap;
            end
        end

        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_DURATION: s_d.dur_lim = reg_wdata_in; // [R1]
                ADDR_QUIET: s_d.quiet_lim = reg_wdata_in; // [R6]
                ADDR_GAP: s_d.gap_lim = reg_wdata_in; // [R11]
                default: s_d.dur_lim = s_q.dur_lim;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_TAP_SOURCE: s_d.rdata = s_q.src;
                ADDR_DURATION: s_d.rdata = s_q.dur_lim;
                ADDR_QUIET: s_d.rdata = s_q.quiet_lim;
                ADDR_GAP: s_d.rdata = s_q.gap_lim;
                default: s_d.rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.dur_lim <= LIMIT_RESET;
            s_q.quiet_lim <= LIMIT_RESET;
            s_q.gap_lim <= LIMIT_RESET;
            s_q.src <= SOURCE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_out = s_q.rdata;
    assign tap_event_pending_out = s_q.src[SRC_ACTIVE_BIT];

    // ========================================================================
    // Assertions
    dur_expire_a: assert property ( // [R1]
        (s_q.st == ST_FIRST && s_q.tl_cnt == s_q.dur_lim)
        |=> s_q.st == ST_IDLE && s_q.src[SRC_ACTIVE_BIT]
        == ($past(s_q.src[SRC_ACTIVE_BIT]) && !$past(src_rd)))
        else $error("duration expiry did not abort the pulse");
    dur_bound_a: assert property ( // [R2]
        (s_q.st == ST_FIRST || s_q.st == ST_SECOND)
        |-> s_q.tl_cnt <= s_q.dur_lim)
        else $error("duration count passed its limit");
    step_mode_a: assert property ( // [R3]
        (tap_filter_enable_in && oversample_mode_in == MODE_HIGH_RES
        && output_sample_rate_in != 3'h0) |-> tl_if.exp == 4'h2)
        else $error("high resolution step wrong");
    step_on_a: assert property ( // [R4]
        (tap_filter_enable_in && output_sample_rate_in == 3'h0) |->
        tl_if.exp == 4'h1)
        else $error("filtered duration step wrong");
    step_off_a: assert property ( // [R5]
        (!tap_filter_enable_in && output_sample_rate_in == 3'h7
        && oversample_mode_in == MODE_NORMAL) |-> tl_if.exp == 4'h3)
        else $error("unfiltered duration cap wrong");
    quiet_ignore_a: assert property ( // [R6]
        (s_q.st == ST_QUIET && rise) |=> s_q.st != ST_FIRST
        && s_q.st != ST_SECOND)
        else $error("pulse accepted during quiet interval");
    quiet_step_a: assert property ( // [R8]
        s_q.st == ST_QUIET |-> qw_if.exp == tl_if.exp + 4'h1)
        else $error("quiet step not twice the duration step");
    quiet_on_a: assert property ( // [R9]
        (tap_filter_enable_in && output_sample_rate_in == 3'h4
        && oversample_mode_in == MODE_NORMAL) |-> qw_if.exp == 4'h6)
        else $error("filtered quiet step wrong");
    quiet_off_a: assert property ( // [R10]
        (!tap_filter_enable_in && output_sample_rate_in == 3'h5
        && oversample_mode_in == MODE_LOWPOWER) |-> qw_if.exp == 4'h7)
        else $error("unfiltered quiet step wrong");
    gap_expire_a: assert property ( // [R11]
        (s_q.st == ST_GAP && s_q.qw_cnt == s_q.gap_lim)
        |=> s_q.st == ST_IDLE)
        else $error("gap window did not expire");
    second_long_a: assert property ( // [R12]
        (s_q.st == ST_SECOND && s_q.tl_cnt == s_q.dur_lim)
        |=> s_q.st == ST_IDLE && !s_q.dbl_done)
        else $error("overlong second pulse accepted");
    gap_step_a: assert property ( // [R13]
        s_q.st == ST_GAP |-> qw_if.exp == tl_if.exp + 4'h1)
        else $error("gap step differs from quiet step");
    start_timing_a: assert property ( // [R14]
        (s_q.st == ST_IDLE && rise)
        |=> s_q.st == ST_FIRST && s_q.tl_cnt == 8'h00)
        else $error("threshold crossing did not start timing");
    read_clear_a: assert property ( // [R15]
        (src_rd && !rep_single && !rep_double) |=> s_q.src == SOURCE_RESET
        && !tap_event_pending_out)
        else $error("source read did not clear flags");
    latch_hold_a: assert property ( // [R16]
        (s_q.src[SRC_ACTIVE_BIT] && event_latch_enable_in && !src_rd)
        |=> s_q.src[6:0] == $past(s_q.src[6:0]))
        else $error("latched status bits changed");

endmodule

//--- tb/host_model.sv
// Host side model: drives the register strobes of the tap timing block.
`timescale 1ns/10ps
module host_model (
    input wire logic core_clk_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_wdata_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
    end

    // ========================================================================
    // Bus cycles, launched on the falling edge so the strobe is stable.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge core_clk_in);
        reg_wr_out = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge core_clk_in);
        reg_rd_out = 1'b0;
        @(negedge core_clk_in);
        d = reg_rdata_in;
    endtask

    // The quiet interval is always written, also for single tap use.
    task automatic setup(input logic [7:0] dur, input logic [7:0] quiet,
        input logic [7:0] gap);
        wr(8'h26, dur);
        wr(8'h27, quiet);
        wr(8'h28, gap);
    endtask
endmodule

//--- tb/tb.sv
// Self-checking testbench for the tap pulse timing block.
`timescale 1ns/10ps
module tb;
    import tap_timing_pkg::*;
    typedef struct packed {
        logic f;
        logic [1:0] m;
        logic [2:0] r;
        logic [7:0] acc;
        logic [7:0] len;
        logic [7:0] src;
    } row_s;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd, pending;
    logic [7:0] ax = 8'h00;
    logic [7:0] ay = 8'h00;
    logic [7:0] az = 8'h00;
    logic [6:0] thr = 7'h0A;
    logic [2:0] rate = 3'h0;
    logic [1:0] mode = 2'h0;
    logic filt = 1'b1;
    logic latch = 1'b0;
    logic single = 1'b1;
    logic dbl = 1'b0;
    int fails = 0;
    int check_count = 0;
    // Steps are 8/16 cycles at 800 Hz with the filter on and UNIT_COUNT 4.
    row_s rows [9] = '{
        '{1'b0, 2'h1, 3'h7, 8'h20, 8'h96, 8'h90},
        '{1'b1, 2'h0, 3'h0, 8'h20, 8'h08, 8'h90},
        '{1'b1, 2'h0, 3'h0, 8'hE0, 8'h08, 8'h91},
        '{1'b1, 2'h0, 3'h0, 8'h20, 8'h18, 8'h90},
        '{1'b0, 2'h0, 3'h0, 8'h20, 8'h18, 8'h00},
        '{1'b1, 2'h0, 3'h0, 8'h20, 8'h3C, 8'h00},
        '{1'b0, 2'h3, 3'h1, 8'h20, 8'h18, 8'h90},
        '{1'b1, 2'h2, 3'h4, 8'h20, 8'h50, 8'h00},
        '{1'b1, 2'h0, 3'h4, 8'h20, 8'h50, 8'h90}};

    always #4 core_clk_in = ~core_clk_in;

    host_model u_host (.core_clk_in(core_clk_in), .reg_rdata_in(reg_rdata),
        .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_wdata_out(reg_wdata));

    tap_pulse_timing #(.UNIT_COUNT(4)) u_dut (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .sample_valid_in(1'b1),
        .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az),
        .x_tap_threshold_in(thr), .y_tap_threshold_in(thr),
        .z_tap_threshold_in(thr), .output_sample_rate_in(rate),
        .oversample_mode_in(mode), .tap_filter_enable_in(filt),
        .event_latch_enable_in(latch), .single_tap_enable_in(single),
        .double_tap_enable_in(dbl), .tap_event_pending_out(pending));

    // ========================================================================
    // Helpers
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic pulse(input logic on_y, input logic [7:0] v, input int n);
        @(negedge core_clk_in);
        if (on_y) ay = v;
        else ax = v;
        repeat (n) @(negedge core_clk_in);
        ax = 8'h00;
        ay = 8'h00;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge core_clk_in);
        fails++;
        report_and_stop();
    end

    // ========================================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge core_clk_in);
        reset_in = 1'b0;
        check("pending", {7'h00, pending}, 8'h00);
        for (int a = 8'h26; a <= 8'h28; a++) begin
            u_host.rd(8'(a), rv);
            check("reset", rv, LIMIT_RESET);
            u_host.wr(8'(a), LIMIT_MAX);
            u_host.rd(8'(a), rv);
            check("max", rv, 8'hFF);
        end
        u_host.rd(8'h30, rv);
        check("unmapped", rv, 8'h00);
        u_host.wr(8'h22, 8'hFF);
        u_host.rd(8'h22, rv);
        check("source ro", rv, 8'h00);
        u_host.setup(8'h04, 8'h02, 8'h04);
        foreach (rows[i]) begin
            filt = rows[i].f;
            mode = rows[i].m;
            rate = rows[i].r;
            pulse(1'b0, rows[i].acc, int'(rows[i].len));
            idle(12);
            check("row pend", {7'h00, pending}, 8'(rows[i].src[7]));
            u_host.rd(8'h22, rv);
            check("row src", rv, rows[i].src);
            idle(2);
            check("cleared", {7'h00, pending}, 8'h00);
            idle(600);
        end
        filt = 1'b1;
        mode = 2'h0;
        rate = 3'h0;
        pulse(1'b0, 8'h20, 8);
        idle(12);
        u_host.rd(8'h22, rv);
        pulse(1'b0, 8'h20, 8);
        idle(12);
        check("quiet", {7'h00, pending}, 8'h00);
        idle(600);
        latch = 1'b1;
        pulse(1'b0, 8'h20, 8);
        idle(50);
        pulse(1'b1, 8'hE0, 8);
        idle(12);
        u_host.rd(8'h22, rv);
        check("latched", rv, 8'h90);
        latch = 1'b0;
        idle(600);
        single = 1'b0;
        dbl = 1'b1;
        pulse(1'b0, 8'h20, 8);
        idle(40);
        check("no single", {7'h00, pending}, 8'h00);
        pulse(1'b0, 8'hE0, 8);
        idle(12);
        u_host.rd(8'h22, rv);
        check("double", rv, 8'h99);
        idle(600);
        pulse(1'b0, 8'h20, 8);
        idle(150);
        pulse(1'b0, 8'h20, 8);
        idle(12);
        check("gap over", {7'h00, pending}, 8'h00);
        idle(600);
        pulse(1'b0, 8'h20, 8);
        idle(40);
        pulse(1'b0, 8'h20, 60);
        idle(12);
        check("long 2nd", {7'h00, pending}, 8'h00);
        idle(600);
        pulse(1'b0, 8'h20, 8);
        idle(88);
        pulse(1'b0, 8'h20, 24);
        idle(12);
        u_host.rd(8'h22, rv);
        check("late end", rv, 8'h98);
        report_and_stop();
    end
endmodule
